// ---- cgpr_pkg.sv ----
/*
  Package for the CAN general purpose register block: register offsets,
  field positions, reset values and resynchronisation counts.
  Assumes an 8-bit register port with one-cycle strobes.
*/
`default_nettype none
package cgpr_pkg;
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_ENABLES = 4'h1;
  localparam logic [3:0] OFF_NODE = 4'h2;
  localparam logic [3:0] OFF_PRESCALE = 4'h3;
  localparam logic [3:0] OFF_TIMING = 4'h4;
  localparam logic [3:0] OFF_PAGE = 4'h5;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h23;
  localparam logic [7:0] RST_PAGE = 8'h00;
  // Flag register bits.
  localparam int B_RX3 = 7;
  localparam int B_RX2 = 6;
  localparam int B_RX1 = 5;
  localparam int B_TXD = 4;
  localparam int B_SCF = 3;
  localparam int B_ORF = 2;
  localparam int B_TEF = 1;
  localparam int B_EPN = 0;
  // Enable register bits.
  localparam int B_EXTENDED_STATUS_CHANGE = 6;
  localparam int B_RX_IRQ_ENABLE = 5;
  localparam int B_TX_IRQ_ENABLE = 4;
  localparam int B_STATUS_CHANGE_IRQ_ENABLE = 3;
  localparam int B_OVERRUN_IRQ_ENABLE = 2;
  localparam int B_TX_ERROR_IRQ_ENABLE = 1;
  localparam int B_ETX = 0;
  // Node control/status bits.
  localparam int B_BUS_OFF_STATE = 6;
  localparam int B_ERROR_PASSIVE_STATE = 5;
  localparam int B_SELF_RECEPTION_ENABLE = 4;
  localparam int B_NO_RETRANSMIT = 3;
  localparam int B_FAST_SYNC = 2;
  localparam int B_WAKE_PULSE = 1;
  localparam int B_RUN = 0;
  localparam logic [7:0] NODE_SW_MASK = 8'h1E;
  localparam logic [7:0] ENABLES_MASK = 8'h7F;
  localparam logic [7:0] PAGE_MASK = 8'h07;
  localparam int RECESSIVE_RUN = 11;
  localparam int SLOW_SEQUENCES = 128;
  localparam logic [3:0] RUN_LEN = 4'(RECESSIVE_RUN);
  localparam logic [7:0] SEQ_LEN = 8'(SLOW_SEQUENCES);
  localparam logic [8:0] BUS_OFF_STATE_LIMIT = 9'h0FF;
  localparam logic [2:0] PAGE_FILTERS = 3'h4;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_WAKE = 4'b0010,
    ST_RESYNC = 4'b0100,
    ST_RUNNING = 4'b1000
  } cgpr_mode_t;
endpackage
`default_nettype wire

// ---- cgpr_regs.sv ----
/*
  General purpose register set of a CAN controller: interrupt flags and
  enables, node control/status, bit timing and the page selector.
  Assumes the protocol engine reports events as one-cycle pulses and
  presents one received bus bit per bit_tick, synchronous to core_clk.
*/
// Function
// - Receive flag per buffer sets on stored message; clears by software or ready clear.
// - Transmit flag sets on success, or on arbitration win with early mode.
// - Status flag sets on standby dominant, passive/bus-off change, optional receive errors.
// - Overrun flag sets when an accepted message finds no free buffer.
// - Transmit error flag sets on error sending the top queued message.
// - Error pending reads as OR of status, overrun and transmit error flags.
// - Writing zero to a flag bit clears that flag.
// - Five enables gate interrupt requests from their matching events.
// - Bus-off bit set while transmit errors exceed 255, cleared once they fall to 255 or below.
// - Error passive bit set only while the node is error passive.
// - Self reception control decides whether own frames are received.
// - No-retransmit control stops retries of failed transmissions.
// - Leaving standby waits one run of 11 recessive bits or 128.
// - Wake pulse control sends a dominant bit on leaving standby.
// - Run starts after resync; cleared run reads one until standby.
// - Prescaler and jump width set quantum and resync adjustment.
// - Segment fields set segment lengths; bit lasts both plus three quanta.
// - Prescaler and timing registers accept writes only in standby.
// - Page field selects diagnosis, buffers one to three or filters.
`default_nettype none
module cgpr_regs
  import cgpr_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Events from the protocol engine.
  input wire logic [2:0] rx_stored,
  input wire logic [2:0] buf_ready_clr,
  input wire logic tx_success,
  input wire logic tx_arb_won,
  input wire logic tx_error,
  input wire logic rx_error,
  input wire logic rx_overrun,
  input wire logic transfer_active,
  input wire logic [8:0] tx_err_count,
  input wire logic error_passive_in,
  input wire logic bus_bit,
  input wire logic bit_tick,
  // Controls to the protocol engine.
  output logic irq_rx,
  output logic irq_tx,
  output logic irq_status,
  output logic irq_overrun,
  output logic irq_tx_error,
  output logic early_tx_irq,
  output logic self_reception_enable,
  output logic no_retransmit,
  output logic wake_pulse_drive,
  output logic engine_running,
  output logic [5:0] quantum_prescale,
  output logic [1:0] jump_width,
  output logic [3:0] segment_one_len,
  output logic [2:0] segment_two_len,
  output logic [2:0] page_sel,
  output logic page_reserved
);
  logic [7:1] flags_q;
  logic [7:0] enables_q;
  logic [4:1] node_ctl_q;
  logic run_q;
  logic bus_off_q;
  logic passive_q;
  logic [7:0] prescale_q;
  logic [7:0] timing_q;
  logic [2:0] page_q;
  logic [7:0] rdata_q;
  cgpr_mode_t mode_q;
  logic [3:0] rec_run_q;
  logic [7:0] seq_cnt_q;
  logic bus_off_state_seen_q;
  logic wr_flags;
  logic in_standby;
  logic bus_off_now;
  logic status_evt;
  logic standby_dom;
  logic [7:1] set_vec;

  assign wr_flags = reg_wr && (reg_addr == OFF_FLAGS);
  assign in_standby = (mode_q == ST_STANDBY);
  assign bus_off_now = (tx_err_count > BUS_OFF_STATE_LIMIT);
  assign standby_dom = in_standby && bit_tick && !bus_bit;
  assign status_evt = standby_dom
    || (!in_standby && (bus_off_now != bus_off_q))
    || (!in_standby && !bus_off_now && (error_passive_in != passive_q))
    || (enables_q[B_EXTENDED_STATUS_CHANGE] && rx_error);

  // Hardware set events, one per flag bit.
  assign set_vec[B_RX3] = rx_stored[2];
  assign set_vec[B_RX2] = rx_stored[1];
  assign set_vec[B_RX1] = rx_stored[0];
  assign set_vec[B_TXD] = enables_q[B_ETX] ? tx_arb_won : tx_success;
  assign set_vec[B_SCF] = status_evt;
  assign set_vec[B_ORF] = rx_overrun;
  assign set_vec[B_TEF] = tx_error;

  // Set wins over any clear arriving in the same cycle.
  for (genvar i = 1; i < 8; i++) begin : g_flag
    logic clr;
    if (i >= B_RX1) begin : g_rx
      assign clr = (wr_flags && !reg_wdata[i])
        || buf_ready_clr[i - B_RX1];
    end else begin : g_other
      assign clr = wr_flags && !reg_wdata[i];
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        flags_q[i] <= RST_FLAGS[i];
      end else if (set_vec[i]) begin
        flags_q[i] <= 1'b1;
      end else if (clr) begin
        flags_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enables_q <= RST_ENABLES;
    end else if (reg_wr && reg_addr == OFF_ENABLES) begin
      enables_q <= reg_wdata & ENABLES_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      node_ctl_q <= RST_NODE[4:1];
    end else if (reg_wr && reg_addr == OFF_NODE) begin
      node_ctl_q <= reg_wdata[4:1];
    end
  end

  // Run request as last written by software; the mode machine follows it.
  // The read-back stays one after a clear until standby is reached.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= RST_NODE[B_RUN];
    end else if (reg_wr && reg_addr == OFF_NODE) begin
      run_q <= reg_wdata[B_RUN];
    end
  end

  // Bus-off and error passive track the engine in every mode, not only while running.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_off_q <= 1'b0;
      passive_q <= 1'b0;
    end else begin
      bus_off_q <= bus_off_now;
      passive_q <= error_passive_in && !bus_off_now;
    end
  end

  // Both timing registers are locked outside standby.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_q <= RST_PRESCALE;
      timing_q <= RST_TIMING;
    end else if (reg_wr && in_standby) begin
      if (reg_addr == OFF_PRESCALE) begin
        prescale_q <= reg_wdata;
      end
      if (reg_addr == OFF_TIMING) begin
        timing_q <= {1'b0, reg_wdata[6:0]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= RST_PAGE[2:0];
    end else if (reg_wr && reg_addr == OFF_PAGE) begin
      page_q <= reg_wdata[2:0];
    end
  end

  // Operating mode: standby, optional wake pulse, resync, running.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= ST_STANDBY;
      rec_run_q <= 4'h0;
      seq_cnt_q <= 8'h00;
      bus_off_state_seen_q <= 1'b0;
    end else begin
      if (bus_off_now) begin
        bus_off_state_seen_q <= 1'b1;
      end
      unique case (mode_q)
        ST_STANDBY: begin
          rec_run_q <= 4'h0;
          seq_cnt_q <= 8'h00;
          if (run_q) begin
            mode_q <= node_ctl_q[B_WAKE_PULSE] ? ST_WAKE : ST_RESYNC;
          end
        end
        ST_WAKE: begin
          if (bit_tick) begin
            mode_q <= ST_RESYNC;
          end
        end
        ST_RESYNC: begin
          if (!run_q) begin
            mode_q <= ST_STANDBY;
          end else if (bit_tick) begin
            if (!bus_bit) begin
              rec_run_q <= 4'h0;
            end else if (rec_run_q == RUN_LEN - 4'h1) begin
              rec_run_q <= 4'h0;
              // Fast sync only applies when not leaving bus-off.
              if ((node_ctl_q[B_FAST_SYNC] && !bus_off_state_seen_q)
                  || seq_cnt_q == SEQ_LEN - 8'h01) begin
                mode_q <= ST_RUNNING;
                seq_cnt_q <= 8'h00;
                bus_off_state_seen_q <= 1'b0;
              end else begin
                seq_cnt_q <= seq_cnt_q + 8'h01;
              end
            end else begin
              rec_run_q <= rec_run_q + 4'h1;
            end
          end
        end
        ST_RUNNING: begin
          if (!run_q && !transfer_active) begin
            mode_q <= ST_STANDBY;
          end else if (bus_off_now) begin
            mode_q <= ST_RESYNC;
          end
        end
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_FLAGS: rdata_q <= {flags_q,
          flags_q[B_SCF] | flags_q[B_ORF] | flags_q[B_TEF]};
        OFF_ENABLES: rdata_q <= enables_q;
        OFF_NODE: rdata_q <= {1'b0, bus_off_q, passive_q, node_ctl_q,
          run_q | !in_standby};
        OFF_PRESCALE: rdata_q <= prescale_q;
        OFF_TIMING: rdata_q <= timing_q;
        OFF_PAGE: rdata_q <= {5'h00, page_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Registered outputs to the engine.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_rx <= 1'b0;
      irq_tx <= 1'b0;
      irq_status <= 1'b0;
      irq_overrun <= 1'b0;
      irq_tx_error <= 1'b0;
      early_tx_irq <= 1'b0;
      self_reception_enable <= 1'b0;
      no_retransmit <= 1'b0;
      wake_pulse_drive <= 1'b0;
      engine_running <= 1'b0;
      quantum_prescale <= RST_PRESCALE[5:0];
      jump_width <= RST_PRESCALE[7:6];
      segment_one_len <= RST_TIMING[3:0];
      segment_two_len <= RST_TIMING[6:4];
      page_sel <= RST_PAGE[2:0];
      page_reserved <= 1'b0;
    end else begin
      irq_rx <= enables_q[B_RX_IRQ_ENABLE] && (|set_vec[7:5]);
      irq_tx <= enables_q[B_TX_IRQ_ENABLE] && set_vec[B_TXD];
      irq_status <= enables_q[B_STATUS_CHANGE_IRQ_ENABLE] && set_vec[B_SCF];
      irq_overrun <= enables_q[B_OVERRUN_IRQ_ENABLE] && set_vec[B_ORF];
      irq_tx_error <= enables_q[B_TX_ERROR_IRQ_ENABLE] && set_vec[B_TEF];
      early_tx_irq <= enables_q[B_ETX];
      self_reception_enable <= node_ctl_q[B_SELF_RECEPTION_ENABLE];
      no_retransmit <= node_ctl_q[B_NO_RETRANSMIT];
      wake_pulse_drive <= (mode_q == ST_WAKE);
      engine_running <= (mode_q == ST_RUNNING);
      quantum_prescale <= prescale_q[5:0];
      jump_width <= prescale_q[7:6];
      segment_one_len <= timing_q[3:0];
      segment_two_len <= timing_q[6:4];
      page_sel <= page_q;
      page_reserved <= (page_q > PAGE_FILTERS);
    end
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ---- cgpr_regs_checker.sv ----
/*
  Checker for the CAN general purpose register block.
  Assumes it sees only the block's ports, attached by the bind below.
*/
`default_nettype none
module cgpr_regs_checker
  import cgpr_pkg::*;
(
  // Clock, reset and register port.
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Engine events.
  input wire logic [2:0] rx_stored,
  input wire logic tx_success,
  input wire logic tx_arb_won,
  input wire logic tx_error,
  input wire logic rx_overrun,
  // Block outputs.
  input wire logic irq_rx,
  input wire logic irq_tx,
  input wire logic irq_overrun,
  input wire logic irq_tx_error,
  input wire logic [2:0] page_sel,
  input wire logic page_reserved
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_rx_irq_cause:
    assert property (irq_rx |-> $past(|rx_stored))
    else $error("receive request without a stored message");
  a_tx_irq_cause:
    assert property (irq_tx |-> $past(tx_success || tx_arb_won))
    else $error("transmit request without a transmit event");
  a_ovr_irq_cause:
    assert property (irq_overrun |-> $past(rx_overrun))
    else $error("overrun request without an overrun");
  a_txe_irq_cause:
    assert property (irq_tx_error |-> $past(tx_error))
    else $error("transmit error request without an error");
  a_pending_or:
    assert property (reg_rd && reg_addr == OFF_FLAGS
      |=> reg_rdata[B_EPN] == |reg_rdata[3:1])
    else $error("pending bit differs from the error flags");
  a_page_write:
    assert property (reg_wr && reg_addr == OFF_PAGE
      |=> ##1 page_sel == 3'($past(reg_wdata, 2)))
    else $error("page select did not take the written code");
  a_page_reserved:
    assert property (page_reserved == (page_sel > PAGE_FILTERS))
    else $error("reserved page indication wrong");
  a_rdata_idle:
    assert property (!reg_rd ##1 !reg_rd |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  c_rx_irq: cover property (irq_rx);
  c_reserved: cover property (page_reserved);
  c_pending: cover property (reg_rd ##1 reg_rdata[B_EPN]);
endmodule
bind cgpr_regs cgpr_regs_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_stored(rx_stored), .tx_success(tx_success),
  .tx_arb_won(tx_arb_won), .tx_error(tx_error), .rx_overrun(rx_overrun),
  .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_overrun(irq_overrun),
  .irq_tx_error(irq_tx_error), .page_sel(page_sel),
  .page_reserved(page_reserved));
`default_nettype wire

// ---- cgpr_bus_model.sv ----
/*
  Bus side model: one bit tick every four core cycles and the bus level.
  Assumes the bench requests dominant periods and the block's wake drive.
*/
`default_nettype none
module cgpr_bus_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Dominant sources and sampled bus.
  input wire logic dom,
  input wire logic wake_in,
  output logic bus_bit,
  output logic bit_tick
);
  logic [1:0] div_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign bit_tick = (div_q == 2'h3);
  // The bus is wired-AND: any dominant source wins, idle is recessive.
  assign bus_bit = ~(dom | wake_in);
endmodule
`default_nettype wire

// ---- cgpr_regs_tb_top.sv ----
/*
  Self-checking bench for the CAN general purpose register block.
  Assumes the bus model on the engine side and a 40 MHz core clock.
*/
`default_nettype none
module cgpr_regs_tb_top import cgpr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, evt = 8'h00, reg_rdata;
  logic [2:0] buf_ready_clr = 3'h0;
  logic dom = 1'b0, transfer_active = 1'b0, error_passive_in = 1'b0;
  logic [8:0] tx_err_count = 9'h000;
  wire [2:0] rx_stored;
  wire tx_success, tx_arb_won, tx_error, rx_error, rx_overrun;
  logic bus_bit, bit_tick, irq_rx, irq_tx, irq_status, irq_overrun;
  logic irq_tx_error, early_tx_irq, self_reception_enable, no_retransmit;
  logic wake_pulse_drive, engine_running, page_reserved;
  logic [5:0] quantum_prescale;
  logic [1:0] jump_width;
  logic [3:0] segment_one_len;
  logic [2:0] segment_two_len, page_sel;
  int n_fail = 0, tests_run = 0, cyc = 0, i;
  assign {rx_stored, tx_success, tx_arb_won, tx_error, rx_error,
    rx_overrun} = evt;
  cgpr_regs u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_stored(rx_stored),
    .buf_ready_clr(buf_ready_clr), .tx_success(tx_success),
    .tx_arb_won(tx_arb_won), .tx_error(tx_error), .rx_error(rx_error),
    .rx_overrun(rx_overrun), .transfer_active(transfer_active),
    .tx_err_count(tx_err_count), .error_passive_in(error_passive_in),
    .bus_bit(bus_bit), .bit_tick(bit_tick), .irq_rx(irq_rx),
    .irq_tx(irq_tx), .irq_status(irq_status), .irq_overrun(irq_overrun),
    .irq_tx_error(irq_tx_error), .early_tx_irq(early_tx_irq),
    .self_reception_enable(self_reception_enable),
    .no_retransmit(no_retransmit), .wake_pulse_drive(wake_pulse_drive),
    .engine_running(engine_running), .quantum_prescale(quantum_prescale),
    .jump_width(jump_width), .segment_one_len(segment_one_len),
    .segment_two_len(segment_two_len), .page_sel(page_sel),
    .page_reserved(page_reserved));
  cgpr_bus_model u_bus (.core_clk(core_clk), .arst_n(arst_n), .dom(dom),
    .wake_in(wake_pulse_drive), .bus_bit(bus_bit), .bit_tick(bit_tick));
  always #12.5 core_clk = ~core_clk;
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge core_clk);
    evt <= v;
    tick(1);
    evt <= 8'h00;
  endtask
  task automatic t_reset_access();
    rd(OFF_FLAGS, 8'h00);
    rd(OFF_ENABLES, 8'h00);
    rd(OFF_NODE, 8'h00);
    rd(OFF_PRESCALE, 8'h00);
    rd(OFF_TIMING, 8'h23);
    rd(OFF_PAGE, 8'h00);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    wr(OFF_ENABLES, 8'hFF);
    rd(OFF_ENABLES, 8'h7F);
    wr(OFF_PRESCALE, 8'hC5);
    wr(OFF_TIMING, 8'hFF);
    rd(OFF_TIMING, 8'h7F);
    chk({jump_width, quantum_prescale}, 8'hC5);
    chk({1'b0, segment_two_len, segment_one_len}, 8'h7F);
    wr(OFF_PAGE, 8'hFD);
    rd(OFF_PAGE, 8'h05);
    chk({4'h0, page_reserved, page_sel}, 8'h0D);
    wr(OFF_PAGE, 8'h04);
    tick(1);
    chk({4'h0, page_reserved, page_sel}, 8'h04);
  endtask
  task automatic t_flags();
    wr(OFF_ENABLES, 8'h20);
    ev(8'h20);
    chk({7'h0, irq_rx}, 8'h01);
    ev(8'hC0);
    rd(OFF_FLAGS, 8'hE0);
    @(posedge core_clk);
    buf_ready_clr <= 3'h1;
    @(posedge core_clk);
    buf_ready_clr <= 3'h0;
    rd(OFF_FLAGS, 8'hC0);
    wr(OFF_FLAGS, 8'hBF);
    rd(OFF_FLAGS, 8'h80);
    wr(OFF_ENABLES, 8'h06);
    ev(8'h21);
    chk({6'h0, irq_rx, irq_overrun}, 8'h01);
    ev(8'h04);
    chk({7'h0, irq_tx_error}, 8'h01);
    rd(OFF_FLAGS, 8'hA7);
    wr(OFF_FLAGS, 8'hFB);
    ev(8'h02);
    rd(OFF_FLAGS, 8'hA3);
    wr(OFF_ENABLES, 8'h48);
    ev(8'h02);
    chk({7'h0, irq_status}, 8'h01);
    rd(OFF_FLAGS, 8'hAB);
    wr(OFF_FLAGS, 8'h00);
    rd(OFF_FLAGS, 8'h00);
  endtask
  task automatic t_transmit();
    wr(OFF_ENABLES, 8'h10);
    ev(8'h08);
    chk({7'h0, irq_tx}, 8'h00);
    ev(8'h10);
    chk({7'h0, irq_tx}, 8'h01);
    rd(OFF_FLAGS, 8'h10);
    wr(OFF_FLAGS, 8'h00);
    wr(OFF_ENABLES, 8'h11);
    ev(8'h08);
    chk({6'h0, early_tx_irq, irq_tx}, 8'h03);
    rd(OFF_FLAGS, 8'h10);
    wr(OFF_FLAGS, 8'h00);
    @(posedge core_clk);
    dom <= 1'b1;
    tick(8);
    dom <= 1'b0;
    rd(OFF_FLAGS, 8'h09);
    wr(OFF_FLAGS, 8'h00);
  endtask
  task automatic t_run_stop();
    wr(OFF_NODE, 8'h1F);
    for (i = 0; i < 10 && wake_pulse_drive !== 1'b1; i++) tick(1);
    chk({7'h0, wake_pulse_drive}, 8'h01);
    chk({6'h0, self_reception_enable, no_retransmit}, 8'h03);
    tick(30);
    chk({7'h0, engine_running}, 8'h00);
    for (i = 0; i < 100 && engine_running !== 1'b1; i++) tick(1);
    chk({7'h0, engine_running}, 8'h01);
    wr(OFF_PRESCALE, 8'h11);
    rd(OFF_PRESCALE, 8'hC5);
    error_passive_in <= 1'b1;
    tick(3);
    rd(OFF_NODE, 8'h3F);
    rd(OFF_FLAGS, 8'h09);
    error_passive_in <= 1'b0;
    transfer_active <= 1'b1;
    wr(OFF_NODE, 8'h1E);
    tick(4);
    rd(OFF_NODE, 8'h1F);
    transfer_active <= 1'b0;
    tick(4);
    rd(OFF_NODE, 8'h1E);
    wr(OFF_PRESCALE, 8'h11);
    rd(OFF_PRESCALE, 8'h11);
    {error_passive_in, tx_err_count} <= 10'h2FF;
    tick(3);
    rd(OFF_NODE, 8'h3E);
    tx_err_count <= 9'h100;
    tick(3);
    rd(OFF_NODE, 8'h5E);
  endtask
  initial begin
    tick(10);
    arst_n <= 1'b1;
    t_reset_access();
    t_flags();
    t_transmit();
    t_run_stop();
    conclude();
  end
endmodule
`default_nettype wire
